/* File: logic/ait_pkg.sv */
`default_nettype none
package ait_pkg;

  // ****************************************
  // widths and timing
  // ****************************************
  localparam int AXES = 2;
  localparam int CNT_W = 31;
  localparam int ADDR_W = 8;
  localparam int CLK_NS = 50;   // 20 MHz system clock
  localparam int TICK_NS = 1000; // one count step is 1 us
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam logic [CNT_W-1:0] LIMIT_RESET = 31'h00000001;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DATA_LOW = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DATA_HIGH = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_READ_DATA = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_AXIS_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] AXIS_STRIDE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_INT_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;

  // ****************************************
  // fields and command codes
  // ****************************************
  localparam int CMD_AXIS_LSB = 8;
  localparam int MODE_REPEAT_BIT = 14;
  localparam int INT_EN_TIMER_BIT = 9;
  localparam int STATUS_RUN_BIT = 10;
  localparam logic [7:0] CMD_SET_LIMIT = 8'h16;
  localparam logic [7:0] CMD_READ_COUNT = 8'h38;
  localparam logic [7:0] CMD_START = 8'h73;
  localparam logic [7:0] CMD_STOP = 8'h74;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // synchronous-action requests aimed at one axis timer
  typedef struct packed {
    logic start;
    logic stop;
    logic capture;
  } ait_sync_t;

endpackage
`default_nettype wire

/* File: logic/ait_tick_div.sv */
`timescale 1ns/1ps
`default_nettype none
module ait_tick_div #(
  parameter int DIV = ait_pkg::TICK_CYCLES
) (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset
  input wire logic clear,   // restart the prescaler
  input wire logic enable,  // count only while enabled
  output logic tick         // one-cycle pulse each microsecond
);
  import ait_pkg::*;

  logic [15:0] phase;

  // ****************************************
  // prescaler
  // ****************************************
  // clear wins so the first tick after a start is a full period away
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 16'h0000;
      tick <= 1'b0;
    end else if (clear || !enable) begin
      phase <= 16'h0000;
      tick <= 1'b0;
    end else if (phase == 16'(DIV - 1)) begin
      phase <= 16'h0000;
      tick <= 1'b1;
    end else begin
      phase <= phase + 16'h0001;
      tick <= 1'b0;
    end
  end

  a_tick_single: assert property (@(posedge clk_sys) disable iff (!reset_n)
    tick |=> !tick) // RULE_18
    else $error("prescaler tick lasted more than one cycle");

endmodule
`default_nettype wire

/* File: logic/ait_axis_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module ait_axis_timer #(
  parameter int DIV = ait_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,                      // system clock
  input wire logic reset_n,                      // async reset
  input wire logic start,                        // start request pulse
  input wire logic stop,                         // stop request pulse
  input wire logic timer_repeat_select,          // 1 repeat, 0 once
  input wire logic [ait_pkg::CNT_W-1:0] limit,   // programmed limit
  output logic running,                          // timer running
  output logic up,                               // expiry pulse
  output logic [ait_pkg::CNT_W-1:0] current_timer_count // live count
);
  import ait_pkg::*;

  logic tick;
  logic [CNT_W-1:0] next_count;

  ait_tick_div #(.DIV(DIV)) u_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clear(start || stop), // RULE_18
    .enable(running),
    .tick(tick)
  );

  assign next_count = current_timer_count + 31'h00000001;

  // ****************************************
  // counter and run state
  // ****************************************
  // a limit lowered below the count mid-run expires on the next tick rather than wrapping
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      running <= 1'b0;
      up <= 1'b0;
      current_timer_count <= '0;
    end else begin
      up <= 1'b0;
      if (stop) begin
        running <= 1'b0; // RULE_10 RULE_17
        current_timer_count <= '0; // RULE_14
      end else if (start) begin
        running <= 1'b1; // RULE_09 RULE_15
        current_timer_count <= '0; // RULE_02
      end else if (running && tick) begin
        if (next_count >= limit) begin // RULE_07
          up <= 1'b1; // RULE_04
          current_timer_count <= '0; // RULE_05 RULE_14
          if (!timer_repeat_select) begin
            running <= 1'b0; // RULE_04 RULE_17
          end
        end else begin
          current_timer_count <= next_count; // RULE_02
        end
      end
    end
  end

  a_stop_clears: assert property (@(posedge clk_sys) disable iff (!reset_n)
    stop |=> !running && current_timer_count == '0) // RULE_10
    else $error("stop did not halt and clear the timer");
  a_start_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    start && !stop |=> running && current_timer_count == '0) // RULE_09
    else $error("start did not run from zero");
  a_expire_limit: assert property (@(posedge clk_sys) disable iff (!reset_n)
    running && tick && !start && !stop && next_count >= limit |=> up && current_timer_count == '0) // RULE_04
    else $error("limit reached without expiry");
  a_once_stops: assert property (@(posedge clk_sys) disable iff (!reset_n)
    up && !$past(timer_repeat_select) && !$past(start) |-> !running) // RULE_17
    else $error("once mode kept running after expiry");
  a_repeat_runs: assert property (@(posedge clk_sys) disable iff (!reset_n)
    up && $past(timer_repeat_select) |-> running) // RULE_05
    else $error("repeat mode halted at expiry");
  a_count_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !running |-> current_timer_count == '0) // RULE_14
    else $error("idle timer holds a nonzero count");

endmodule
`default_nettype wire

/* File: logic/ait_top.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE_01 - each axis has its own timer with separate mode, start, stop, status
// RULE_02 - 31-bit counter starts from zero and steps once per microsecond
// RULE_03 - limit range is 1 to 2,147,483,647 microseconds
// RULE_04 - once mode: count reaching limit expires the timer and stops it
// RULE_05 - repeat mode: after expiry restart from zero until stopped
// RULE_06 - host loads limit via both data registers then command 16h
// RULE_07 - limit may be rewritten while the timer runs
// RULE_08 - mode bit 14 picks once (0) or repeat (1)
// RULE_09 - command 73h or a sync start action starts the timer
// RULE_10 - command 74h or a sync stop action halts it at once
// RULE_11 - expiry is offered as a trigger for synchronous actions
// RULE_12 - sync actions may capture the count, start or stop the timer
// RULE_13 - command 38h reads the live count at any time
// RULE_14 - the count clears to zero whenever the timer stops
// RULE_15 - status bit 10 reads 1 from the moment the timer starts
// RULE_16 - interrupt enable bit 9 lets expiry raise the interrupt request
// RULE_17 - running flag drops whenever the timer stops, any cause
// RULE_18 - microsecond prescaler restarts together with the counter on start
module ait_top #(
  parameter int DIV = ait_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,                             // system clock
  input wire logic reset_n,                             // async reset
  input wire logic [ait_pkg::ADDR_W-1:0] s_axi_awaddr,  // write address
  input wire logic s_axi_awvalid,                       // write address valid
  output logic s_axi_awready,                           // write address ready
  input wire logic [31:0] s_axi_wdata,                  // write data
  input wire logic [3:0] s_axi_wstrb,                   // byte enables
  input wire logic s_axi_wvalid,                        // write data valid
  output logic s_axi_wready,                            // write data ready
  output logic [1:0] s_axi_bresp,                       // write response
  output logic s_axi_bvalid,                            // write response valid
  input wire logic s_axi_bready,                        // write response ready
  input wire logic [ait_pkg::ADDR_W-1:0] s_axi_araddr,  // read address
  input wire logic s_axi_arvalid,                       // read address valid
  output logic s_axi_arready,                           // read address ready
  output logic [31:0] s_axi_rdata,                      // read data
  output logic [1:0] s_axi_rresp,                       // read response
  output logic s_axi_rvalid,                            // read data valid
  input wire logic s_axi_rready,                        // read data ready
  input wire ait_pkg::ait_sync_t [ait_pkg::AXES-1:0] sync_req, // sync actions
  output logic [ait_pkg::AXES-1:0] timer_up,            // expiry triggers
  output logic [ait_pkg::AXES-1:0] capture_strobe,      // compare load pulse
  output logic [ait_pkg::AXES-1:0][ait_pkg::CNT_W-1:0] multipurpose_compare_reg, // captured count
  output logic irq                                      // interrupt request
);
  import ait_pkg::*;

  // ****************************************
  // decode helpers
  // ****************************************
  // axis index of a per-axis address, AXES below the axis window and AXES or more above it
  function automatic int axis_of(input logic [ADDR_W-1:0] addr);
    int idx;
    idx = AXES;
    if (addr >= OFS_AXIS_BASE) begin
      idx = int'((addr - OFS_AXIS_BASE) / AXIS_STRIDE);
    end
    return idx;
  endfunction

  // offset inside the axis block
  function automatic logic [ADDR_W-1:0] axis_ofs(input logic [ADDR_W-1:0] addr);
    return (addr - OFS_AXIS_BASE) % AXIS_STRIDE;
  endfunction

  // whether an address names a register
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr == OFS_CMD || addr == OFS_DATA_LOW || addr == OFS_DATA_HIGH || addr == OFS_READ_DATA) begin
      hit = 1'b1;
    end else if (axis_of(addr) < AXES) begin
      hit = axis_ofs(addr) == OFS_MODE || axis_ofs(addr) == OFS_INT_EN || axis_ofs(addr) == OFS_STATUS;
    end
    return hit;
  endfunction

  // merge the two low byte lanes of a 16-bit register
  function automatic logic [15:0] lanes16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [15:0] data_low_write_reg;
  logic [15:0] data_high_write_reg;
  logic [CNT_W-1:0] read_count;
  logic [AXES-1:0] timer_repeat_select;
  logic [AXES-1:0] int_enable;
  logic [AXES-1:0][CNT_W-1:0] limit;
  logic [AXES-1:0] cmd_start;
  logic [AXES-1:0] cmd_stop;
  logic [AXES-1:0] running;
  logic [AXES-1:0] up;
  logic [AXES-1:0][CNT_W-1:0] count;
  logic [7:0] cmd_code;
  logic [AXES-1:0] cmd_axes;
  logic [CNT_W-1:0] next_limit;
  int wr_axis;

  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign cmd_code = w_data[7:0];
  assign cmd_axes = w_data[CMD_AXIS_LSB +: AXES];
  assign next_limit = {data_high_write_reg[CNT_W-17:0], data_low_write_reg};
  assign wr_axis = axis_of(aw_addr);

  // ****************************************
  // write channel
  // ****************************************
  // address and data are caught in either order; the register write
  // waits until both are held and the previous response has gone
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_wready <= 1'b1;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      s_axi_wready <= 1'b1;
    end
  end

  // response; unmapped addresses answer with slave error
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= reg_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // shared data registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_low_write_reg <= 16'h0000;
      data_high_write_reg <= 16'h0000;
    end else if (do_write && aw_addr == OFS_DATA_LOW) begin
      data_low_write_reg <= lanes16(data_low_write_reg, w_data, w_strb); // RULE_06
    end else if (do_write && aw_addr == OFS_DATA_HIGH) begin
      data_high_write_reg <= lanes16(data_high_write_reg, w_data, w_strb); // RULE_06
    end
  end

  // ****************************************
  // per-axis settings and commands
  // ****************************************
  // a zero limit would expire on every tick, so a zero load is ignored
  for (genvar i = 0; i < AXES; i++) begin : g_axis
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        timer_repeat_select[i] <= 1'b0;
        int_enable[i] <= 1'b0;
      end else if (do_write && wr_axis == i && w_strb[1]) begin
        if (axis_ofs(aw_addr) == OFS_MODE) begin
          timer_repeat_select[i] <= w_data[MODE_REPEAT_BIT]; // RULE_08
        end else if (axis_ofs(aw_addr) == OFS_INT_EN) begin
          int_enable[i] <= w_data[INT_EN_TIMER_BIT]; // RULE_16
        end
      end
    end

    // command pulses land one cycle after the bus write
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        cmd_start[i] <= 1'b0;
        cmd_stop[i] <= 1'b0;
        limit[i] <= LIMIT_RESET;
      end else begin
        cmd_start[i] <= 1'b0;
        cmd_stop[i] <= 1'b0;
        if (do_write && aw_addr == OFS_CMD && w_strb[0] && cmd_axes[i]) begin
          cmd_start[i] <= cmd_code == CMD_START; // RULE_09
          cmd_stop[i] <= cmd_code == CMD_STOP; // RULE_10
          if (cmd_code == CMD_SET_LIMIT && next_limit != '0) begin
            limit[i] <= next_limit; // RULE_03 RULE_07
          end
        end
      end
    end

    ait_axis_timer #(.DIV(DIV)) u_timer ( // RULE_01
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .start(cmd_start[i] || sync_req[i].start), // RULE_12
      .stop(cmd_stop[i] || sync_req[i].stop), // RULE_12
      .timer_repeat_select(timer_repeat_select[i]),
      .limit(limit[i]),
      .running(running[i]),
      .up(up[i]),
      .current_timer_count(count[i])
    );

    // count capture into the compare register on a sync action
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        capture_strobe[i] <= 1'b0;
        multipurpose_compare_reg[i] <= '0;
      end else begin
        capture_strobe[i] <= sync_req[i].capture;
        if (sync_req[i].capture) begin
          multipurpose_compare_reg[i] <= count[i]; // RULE_12
        end
      end
    end

    a_capture_value: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sync_req[i].capture |=> capture_strobe[i] && multipurpose_compare_reg[i] == $past(count[i])) // RULE_12
      else $error("captured count does not match the live count");
  end

  assign timer_up = up; // RULE_11

  // ****************************************
  // live count readback
  // ****************************************
  // with both axes selected the lower axis wins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      read_count <= '0;
    end else if (do_write && aw_addr == OFS_CMD && w_strb[0] && cmd_code == CMD_READ_COUNT) begin
      if (cmd_axes[0]) begin
        read_count <= count[0]; // RULE_13
      end else if (cmd_axes[1]) begin
        read_count <= count[1]; // RULE_13
      end
    end
  end

  // ****************************************
  // interrupt request
  // ****************************************
  // a one-cycle request per expiry; the host side latches it if needed
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(up & int_enable); // RULE_16
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata <= 32'h00000000;
      if (s_axi_araddr == OFS_DATA_LOW) begin
        s_axi_rdata <= {16'h0000, data_low_write_reg};
      end else if (s_axi_araddr == OFS_DATA_HIGH) begin
        s_axi_rdata <= {16'h0000, data_high_write_reg};
      end else if (s_axi_araddr == OFS_READ_DATA) begin
        s_axi_rdata <= {1'b0, read_count}; // RULE_13
      end else if (axis_of(s_axi_araddr) < AXES) begin
        if (axis_ofs(s_axi_araddr) == OFS_MODE) begin
          s_axi_rdata[MODE_REPEAT_BIT] <= timer_repeat_select[axis_of(s_axi_araddr)];
        end else if (axis_ofs(s_axi_araddr) == OFS_INT_EN) begin
          s_axi_rdata[INT_EN_TIMER_BIT] <= int_enable[axis_of(s_axi_araddr)];
        end else if (axis_ofs(s_axi_araddr) == OFS_STATUS) begin
          s_axi_rdata[STATUS_RUN_BIT] <= running[axis_of(s_axi_araddr)]; // RULE_15
        end
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_irq_expiry: assert property (@(posedge clk_sys) disable iff (!reset_n)
    |(up & int_enable) |=> irq) // RULE_16
    else $error("enabled expiry did not raise the interrupt");
  a_irq_masked: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !(|(up & int_enable)) |=> !irq) // RULE_16
    else $error("interrupt raised without an enabled expiry");
  a_cmd_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
    do_write && aw_addr == OFS_CMD && w_strb[0] && cmd_code == CMD_START && cmd_axes[0]
      && !sync_req[0].stop |=> ##1 running[0]) // RULE_15
    else $error("start command did not set the running flag");
  a_cmd_stop: assert property (@(posedge clk_sys) disable iff (!reset_n)
    do_write && aw_addr == OFS_CMD && w_strb[0] && cmd_code == CMD_STOP && cmd_axes[1]
      |=> ##1 !running[1] && count[1] == '0) // RULE_10
    else $error("stop command did not halt the timer");
  a_limit_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
    do_write && aw_addr == OFS_CMD && w_strb[0] && cmd_code == CMD_SET_LIMIT && cmd_axes[1]
      && next_limit != '0 |=> limit[1] == $past(next_limit)) // RULE_06
    else $error("limit load command did not take the data registers");
  a_write_resp: assert property (@(posedge clk_sys) disable iff (!reset_n)
    do_write |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write did not answer in one cycle");

endmodule
`default_nettype wire

/* File: bench/ait_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module ait_top_test;
  import ait_pkg::*;
  localparam int DIV = 2; // short prescaler keeps the run brief
  logic clk_sys = 0;
  logic reset_n = 0;
  logic [ADDR_W-1:0] aw_a = '0, ar_a = '0;
  logic [31:0] w_d = '0, r_d, r_dat;
  logic aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq;
  logic [1:0] b_resp, r_resp, rs, t_up, cap;
  logic [1:0][CNT_W-1:0] cmp;
  logic [CNT_W-1:0] exp_c;
  ait_sync_t [1:0] sync_req = '0;
  int mismatches = 0, checks_done = 0, n, lim;
  ait_top #(.DIV(DIV)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_dat), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .sync_req(sync_req), .timer_up(t_up), .capture_strobe(cap), .multipurpose_compare_reg(cmp), .irq(irq));
  // free-running 20 MHz system clock
  always #25 clk_sys = ~clk_sys;
  // ****************************************
  // bus and timer helpers
  // ****************************************
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [7:0] ax_ofs(input int ax, input logic [7:0] o);
    return 8'(OFS_AXIS_BASE + AXIS_STRIDE * ax + o);
  endfunction
  // address and data go out together; each drops once its own ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    aw_a <= a;
    w_d <= d;
    aw_v <= 1;
    w_v <= 1;
    b_r <= 1;
    for (k = 0; k < 100 && !(k > 0 && b_v); k++) begin
      @(posedge clk_sys);
      if (aw_v && aw_rdy) aw_v <= 0;
      if (w_v && w_rdy) w_v <= 0;
    end
    rs = b_resp;
    b_r <= 0;
    if (!b_v) begin mismatches++; tally_and_finish(); end
    @(posedge clk_sys); // one idle edge so no strobe is driven twice in a step
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    ar_a <= a;
    ar_v <= 1;
    r_r <= 1;
    for (k = 0; k < 100 && !(k > 0 && r_v); k++) begin
      @(posedge clk_sys);
      if (ar_v && ar_rdy) ar_v <= 0;
    end
    r_d = r_dat;
    rs = r_resp;
    r_r <= 0;
    if (!r_v) begin mismatches++; tally_and_finish(); end
    @(posedge clk_sys);
  endtask
  task automatic cmd(input int ax, input logic [7:0] code);
    wr(OFS_CMD, 32'(code) | (32'h100 << ax));
  endtask
  task automatic load(input int ax, input logic [CNT_W-1:0] v);
    wr(OFS_DATA_LOW, {16'h0, v[15:0]});
    wr(OFS_DATA_HIGH, {17'h0, v[30:16]});
    cmd(ax, CMD_SET_LIMIT);
  endtask
  task automatic wait_up(input int ax);
    n = 0;
    do begin @(posedge clk_sys); n++; end while (!t_up[ax] && n < 5000);
    if (!t_up[ax]) begin mismatches++; tally_and_finish(); end
  endtask
  task automatic sy(input int ax, input logic [2:0] v);
    sync_req[ax] <= ait_sync_t'(v);
    @(posedge clk_sys);
    sync_req[ax] <= ait_sync_t'(3'h0);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(15756));
    repeat (8) @(posedge clk_sys);
    reset_n <= 1;
    @(posedge clk_sys);
    rd(ax_ofs(0, OFS_STATUS));
    `CHK("idle status", 1'b0, r_d[STATUS_RUN_BIT])
    // once mode on the first axis: runs, expires, stops and clears
    lim = $urandom_range(3, 12);
    load(0, CNT_W'(lim));
    wr(ax_ofs(0, OFS_MODE), 32'h0);
    cmd(0, CMD_START);
    rd(ax_ofs(0, OFS_STATUS));
    `CHK("run flag", 1'b1, r_d[STATUS_RUN_BIT])
    wait_up(0);
    repeat (3) @(posedge clk_sys);
    rd(ax_ofs(0, OFS_STATUS));
    `CHK("once stop", 1'b0, r_d[STATUS_RUN_BIT])
    cmd(0, CMD_READ_COUNT);
    rd(OFS_READ_DATA);
    `CHK("count cleared", 32'h0, r_d)
    // repeat mode on the second axis, limit changed while running, irq on then off
    wr(ax_ofs(1, OFS_MODE), 32'h4000);
    for (int k = 0; k < 2; k++) begin
      lim = $urandom_range(4, 15);
      load(1, CNT_W'(lim));
      wr(ax_ofs(1, OFS_INT_EN), k == 0 ? 32'h200 : 32'h0);
      if (k == 0) cmd(1, CMD_START);
      wait_up(1);
      wait_up(1);
      `CHK("period", lim * DIV, n)
      @(posedge clk_sys);
      `CHK("irq", k == 0, irq)
    end
    rd(ax_ofs(0, OFS_STATUS));
    `CHK("other axis idle", 1'b0, r_d[STATUS_RUN_BIT])
    cmd(1, CMD_STOP);
    rd(ax_ofs(1, OFS_STATUS));
    `CHK("stop cmd", 1'b0, r_d[STATUS_RUN_BIT])
    // sync start at the largest limit, capture mid-run, sync stop
    load(0, 31'h7fffffff);
    sy(0, 3'h4);
    lim = $urandom_range(10, 60);
    repeat (lim) @(posedge clk_sys);
    sy(0, 3'h1);
    @(posedge clk_sys);
    exp_c = CNT_W'((lim + 1) / DIV);
    `CHK("capture pulse", 1'b1, cap[0])
    `CHK("capture value", 1'b1, cmp[0] <= exp_c && cmp[0] + 1 >= exp_c)
    sy(0, 3'h2);
    repeat (3) @(posedge clk_sys);
    rd(ax_ofs(0, OFS_STATUS));
    `CHK("sync stop", 1'b0, r_d[STATUS_RUN_BIT])
    cmd(0, CMD_READ_COUNT);
    rd(OFS_READ_DATA);
    `CHK("count after stop", 32'h0, r_d)
    // unmapped place is refused both ways
    wr(8'h40, 32'h1);
    `CHK("bad write", RESP_SLVERR, rs)
    rd(8'h40);
    `CHK("bad read", RESP_SLVERR, rs)
    tally_and_finish();
  end
endmodule
`default_nettype wire
